// ===== rtl/msh_pkg.sv
// Package of constants and types for the message send handshake block.
package msh_pkg;

	// ----------------------------------------
	// Device types, protocols and limits
	// ----------------------------------------
	localparam logic [15:0] DEV_MULTIDROP = 16'h0001;
	localparam logic [15:0] DEV_SERIAL = 16'h0005;
	localparam logic [15:0] DEV_ETH = 16'h0006;
	localparam logic [15:0] DEV_DNET = 16'h000B;
	localparam logic [15:0] DEV_ETH_SMALL = 16'h0010;
	localparam logic [15:0] PROTO_REGACC = 16'h0001;
	localparam logic [15:0] PROTO_RAW_WORD = 16'h0002;
	localparam logic [15:0] PROTO_RAW_BYTE = 16'h0003;
	localparam logic [15:0] NUM_MIN = 16'h0001;
	localparam logic [15:0] CIR_MAX_SERIAL = 16'h0010;
	localparam logic [15:0] CIR_MAX_OTHER = 16'h0008;
	localparam logic [15:0] CH_MAX_MULTIDROP = 16'h000C;
	localparam logic [15:0] CH_MAX_SERIAL = 16'h0001;
	localparam logic [15:0] CH_MAX_ETH = 16'h000A;
	localparam logic [15:0] CH_MAX_SMALL = 16'h0004;

	// ----------------------------------------
	// Parameter list layout and result codes
	// ----------------------------------------
	localparam int PL_WORDS = 17;
	localparam logic [15:0] PL_RESULT = 16'h0000;
	localparam logic [15:0] PL_DATA_ADDR = 16'h0005;
	localparam logic [15:0] PL_DATA_SIZE = 16'h0006;
	localparam logic [15:0] PL_REG_OFFSET = 16'h000B;
	localparam logic [15:0] PL_LAST = 16'h0010;
	localparam logic [7:0] RES_BUSY = 8'h00;
	localparam logic [7:0] RES_DONE = 8'h10;
	localparam logic [3:0] RES_ERR_HI = 4'h8;
	localparam logic [3:0] ERR_DEV = 4'h1;
	localparam logic [3:0] ERR_PROTO = 4'h2;
	localparam logic [3:0] ERR_CIRCUIT = 4'h3;
	localparam logic [3:0] ERR_CHANNEL = 4'h4;
	localparam logic [3:0] ERR_SHARED = 4'h5;
	localparam logic [1:0] FETCH_LAST = 2'h2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] dev_type;
		logic [15:0] proto;
		logic [15:0] circuit;
		logic [15:0] channel;
	} msh_cmd_t;

	typedef struct packed {
		msh_cmd_t cmd;
		logic word_mode;
		logic no_reply;
		logic [15:0] data_addr;
		logic [15:0] data_size;
		logic [15:0] reg_offset;
	} msh_req_t;

	typedef enum logic [2:0] {
		MSH_IDLE, MSH_START, MSH_FETCH, MSH_SEND, MSH_ABORT, MSH_REPORT, MSH_HOLD
	} msh_state_t;

endpackage

// ===== rtl/msh_send.sv
// Message send handshake: command checking, parameter list access and link control.
// Contract
// - Send starts on execute; caller holds execute until complete or error.
// - Abort abandons the send and wins over execute.
// - Device type codes 1, 5, 6, 11, 16 select the link.
// - Protocols 2 and 3 send raw words or bytes, expecting no reply.
// - Protocol 1 is the register-access family, converted by the link.
// - Circuit 1 to 16 for serial, 1 to 8 for other devices.
// - Channel 1-12 multidrop, 1 serial, 1-10 Ethernet, 1-4 others.
// - Serial link shares one channel, so only one message in flight.
// - Parameter list is 17 words: inputs read, results written back.
// - Busy stays on while a send or abort is in progress.
// - Complete pulses for exactly one scan on normal finish.
// - Error pulses for exactly one scan on an error.
// - Result word upper byte: 00h running, 10h done, 8yh error.
`timescale 1ns/100ps
module msh_send (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Command bits and selectors
	input wire logic exec_i,
	input wire logic abort_i,
	input wire msh_pkg::msh_cmd_t cmd_i,
	input wire logic [15:0] param_base_i,
	// Status bits
	output logic busy_o,
	output logic done_o,
	output logic err_o,
	// Parameter list word port
	output logic [15:0] pl_addr_o,
	output logic [15:0] pl_wdata_o,
	output logic pl_we_o,
	input wire logic [15:0] pl_rdata_i,
	// Transmission device
	output msh_pkg::msh_req_t link_req_o,
	output logic link_start_o,
	output logic link_abort_o,
	input wire logic link_done_i,
	input wire logic link_fail_i,
	input wire logic [3:0] link_fail_code_i,
	input wire logic link_idle_i,
	input wire logic link_rx_busy_i
);
	import msh_pkg::*;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	function automatic logic in_range(input logic [15:0] v, input logic [15:0] hi);
		in_range = (v >= NUM_MIN) && (v <= hi);
	endfunction

	function automatic logic [3:0] check_cmd(input msh_cmd_t c, input logic rx_busy);
		logic [15:0] ch_max;
		logic [15:0] cir_max;
		ch_max = CH_MAX_SMALL;
		cir_max = (c.dev_type == DEV_SERIAL) ? CIR_MAX_SERIAL : CIR_MAX_OTHER;
		case (c.dev_type)
			DEV_MULTIDROP: ch_max = CH_MAX_MULTIDROP;
			DEV_SERIAL: ch_max = CH_MAX_SERIAL;
			DEV_ETH: ch_max = CH_MAX_ETH;
			default: ch_max = CH_MAX_SMALL;
		endcase
		if (!(c.dev_type inside {DEV_MULTIDROP, DEV_SERIAL, DEV_ETH, DEV_DNET, DEV_ETH_SMALL}))
			check_cmd = ERR_DEV;
		else if (!(c.proto inside {PROTO_REGACC, PROTO_RAW_WORD, PROTO_RAW_BYTE}))
			check_cmd = ERR_PROTO;
		else if (!in_range(c.circuit, cir_max))
			check_cmd = ERR_CIRCUIT;
		else if (!in_range(c.channel, ch_max))
			check_cmd = ERR_CHANNEL;
		else if ((c.dev_type == DEV_SERIAL) && rx_busy)
			check_cmd = ERR_SHARED;
		else
			check_cmd = 4'h0;
	endfunction

	msh_state_t state_q;
	logic [1:0] step_q;
	logic [3:0] err_code_q;
	logic fail_q;
	msh_req_t req_q;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Abort is checked first in every active state so that it always wins.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= MSH_IDLE;
			step_q <= 2'h0;
			err_code_q <= 4'h0;
			fail_q <= 1'b0;
		end else begin
			case (state_q)
				MSH_IDLE: begin
					fail_q <= 1'b0;
					err_code_q <= 4'h0;
					if (abort_i) begin
						state_q <= MSH_ABORT;
					end else if (exec_i) begin
						state_q <= MSH_START;
					end
				end
				MSH_START: begin
					step_q <= 2'h0;
					err_code_q <= check_cmd(cmd_i, link_rx_busy_i);
					if (abort_i) begin
						state_q <= MSH_ABORT;
					end else if (check_cmd(cmd_i, link_rx_busy_i) != 4'h0) begin
						fail_q <= 1'b1;
						state_q <= MSH_REPORT;
					end else begin
						state_q <= MSH_FETCH;
					end
				end
				MSH_FETCH: begin
					step_q <= step_q + 2'h1;
					if (abort_i) begin
						state_q <= MSH_ABORT;
					end else if (step_q == FETCH_LAST) begin
						state_q <= MSH_SEND;
					end
				end
				MSH_SEND: begin
					if (abort_i) begin
						state_q <= MSH_ABORT;
					end else if (link_fail_i) begin
						fail_q <= 1'b1;
						err_code_q <= link_fail_code_i;
						state_q <= MSH_REPORT;
					end else if (link_done_i) begin
						state_q <= MSH_REPORT;
					end
				end
				MSH_ABORT: begin
					if (link_idle_i) begin
						fail_q <= 1'b0;
						state_q <= MSH_REPORT;
					end
				end
				MSH_REPORT: state_q <= MSH_HOLD;
				MSH_HOLD: begin
					if (!exec_i && !abort_i) begin
						state_q <= MSH_IDLE;
					end
				end
				default: state_q <= MSH_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Handshake bits
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			err_o <= 1'b0;
		end else begin
			busy_o <= state_q inside {MSH_START, MSH_FETCH, MSH_SEND, MSH_ABORT};
			done_o <= (state_q == MSH_REPORT) && !fail_q;
			err_o <= (state_q == MSH_REPORT) && fail_q;
		end
	end

	// ----------------------------------------
	// Parameter list access
	// ----------------------------------------
	// One shared word port: the progress write goes out before the reads start,
	// so a slow list cannot see a read and a write in the same scan.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pl_addr_o <= 16'h0000;
			pl_wdata_o <= 16'h0000;
			pl_we_o <= 1'b0;
		end else begin
			pl_we_o <= 1'b0;
			case (state_q)
				MSH_IDLE: begin
					if (exec_i && !abort_i) begin
						pl_addr_o <= param_base_i + PL_RESULT;
						pl_wdata_o <= {RES_BUSY, cmd_i.circuit[7:0]};
						pl_we_o <= 1'b1;
					end
				end
				MSH_START: pl_addr_o <= param_base_i + PL_DATA_ADDR;
				MSH_FETCH: begin
					if (step_q == 2'h0) begin
						pl_addr_o <= param_base_i + PL_DATA_SIZE;
					end else begin
						pl_addr_o <= param_base_i + PL_REG_OFFSET;
					end
				end
				MSH_REPORT: begin
					pl_addr_o <= param_base_i + PL_RESULT;
					pl_wdata_o <= fail_q ? {RES_ERR_HI, err_code_q, req_q.cmd.circuit[7:0]} :
						{RES_DONE, req_q.cmd.circuit[7:0]};
					pl_we_o <= 1'b1;
				end
				default: pl_we_o <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// Link request
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			req_q <= '0;
		end else if ((state_q == MSH_START) || ((state_q == MSH_IDLE) && abort_i)) begin
			// An abort from idle never passes START, so its result word needs the circuit here.
			req_q.cmd <= cmd_i;
			req_q.word_mode <= (cmd_i.proto == PROTO_RAW_WORD);
			req_q.no_reply <= (cmd_i.proto != PROTO_REGACC);
		end else if (state_q == MSH_FETCH) begin
			case (step_q)
				2'h0: req_q.data_addr <= pl_rdata_i;
				2'h1: req_q.data_size <= pl_rdata_i;
				default: req_q.reg_offset <= pl_rdata_i;
			endcase
		end
	end

	assign link_req_o = req_q;

	// The start strobe is a single pulse; on the serial device the machine is
	// not back in idle until the send is over, so a second cannot overlap.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			link_start_o <= 1'b0;
			link_abort_o <= 1'b0;
		end else begin
			link_start_o <= (state_q == MSH_FETCH) && (step_q == FETCH_LAST) && !abort_i;
			link_abort_o <= (state_q == MSH_ABORT) && !link_idle_i;
		end
	end

	// ----------------------------------------
	// Checks on the design
	// ----------------------------------------
	done_one_scan_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		done_o |=> !done_o) else $error("complete longer than one scan");
	err_one_scan_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		err_o |=> !err_o) else $error("error longer than one scan");
	done_err_excl_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!(done_o && err_o)) else $error("complete and error together");
	abort_wins_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(state_q == MSH_IDLE && exec_i && abort_i) |=> state_q == MSH_ABORT ##1 busy_o)
		else $error("abort did not win over execute");
	busy_on_exec_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(state_q == MSH_IDLE && exec_i && !abort_i) |=> ##1 busy_o)
		else $error("busy missing after execute");
	done_result_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		done_o |-> pl_we_o && pl_wdata_o[15:8] == RES_DONE)
		else $error("result word not done code");
	err_result_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		err_o |-> pl_we_o && pl_wdata_o[15:12] == RES_ERR_HI)
		else $error("result word not error code");
	bad_channel_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(state_q == MSH_START && !abort_i && cmd_i.dev_type == DEV_SERIAL
		&& cmd_i.channel != CH_MAX_SERIAL) |-> ##[1:3] err_o)
		else $error("bad serial channel not refused");
	word_mode_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		link_start_o |-> link_req_o.word_mode == (link_req_o.cmd.proto == PROTO_RAW_WORD))
		else $error("word mode wrong at start");
	hold_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(state_q == MSH_HOLD && exec_i) |=> !busy_o && !link_start_o)
		else $error("restart without execute release");

endmodule // msh_send

// ===== dv/msh_link_model.sv
// Partner model: parameter list memory and a transmission device.
`timescale 1ns/100ps
module msh_link_model (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Parameter list port
	input wire logic [15:0] pl_addr_o,
	input wire logic [15:0] pl_wdata_o,
	input wire logic pl_we_o,
	output logic [15:0] pl_rdata_i,
	// Transmission device
	input wire logic link_start_o,
	input wire logic link_abort_o,
	output logic link_done_i,
	output logic link_fail_i,
	output logic [3:0] link_fail_code_i,
	output logic link_idle_i,
	// Bench controls
	input wire logic fail_i,
	input wire logic [7:0] delay_i
);
	// ----------------------------------------
	// Memory and link
	// ----------------------------------------
	logic [15:0] mem [256];
	logic [7:0] cnt_q;
	assign pl_rdata_i = mem[pl_addr_o[7:0]];
	// The code only means something with the fail pulse, so it wanders otherwise.
	assign link_fail_code_i = link_fail_i ? 4'h7 : cnt_q[3:0];
	always @(posedge core_clk_i) if (pl_we_o) mem[pl_addr_o[7:0]] <= pl_wdata_o;
	always @(posedge core_clk_i or negedge rstn_i) begin
		link_done_i <= 1'b0;
		link_fail_i <= 1'b0;
		if (!rstn_i) begin
			link_idle_i <= 1'b1;
			cnt_q <= 8'h00;
		end else if (link_start_o) begin
			link_idle_i <= 1'b0;
			cnt_q <= delay_i;
		end else if (!link_idle_i) begin
			cnt_q <= cnt_q - 8'h01;
			if (link_abort_o || cnt_q == 8'h01) link_idle_i <= 1'b1;
			if (!link_abort_o && cnt_q == 8'h01) begin
				link_done_i <= !fail_i;
				link_fail_i <= fail_i;
			end
		end
	end
endmodule // msh_link_model

// ===== dv/msh_send_bench.sv
// Self-checking bench for the message send handshake block.
`timescale 1ns/100ps
module msh_send_bench;
	import msh_pkg::*;
	logic core_clk_i = 0, rstn_i = 0, exec_i = 0, abort_i = 0, link_rx_busy_i = 0, fail_i = 0;
	logic busy_o, done_o, err_o, pl_we_o, link_start_o, link_abort_o;
	logic link_done_i, link_fail_i, link_idle_i;
	logic [15:0] pl_addr_o, pl_wdata_o, pl_rdata_i, base = 16'h0020;
	logic [7:0] delay_i = 8'h04;
	logic [3:0] link_fail_code_i;
	msh_cmd_t cmd_i = '0;
	msh_req_t link_req_o;
	int num_errors = 0, comparisons = 0;
	logic [15:0] devs [5] = '{DEV_MULTIDROP, DEV_SERIAL, DEV_ETH, DEV_DNET, DEV_ETH_SMALL};
	always #4 core_clk_i = ~core_clk_i;
	msh_send DUT (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .exec_i(exec_i), .abort_i(abort_i),
		.cmd_i(cmd_i), .param_base_i(base), .busy_o(busy_o), .done_o(done_o), .err_o(err_o),
		.pl_addr_o(pl_addr_o), .pl_wdata_o(pl_wdata_o), .pl_we_o(pl_we_o), .pl_rdata_i(pl_rdata_i),
		.link_req_o(link_req_o), .link_start_o(link_start_o), .link_abort_o(link_abort_o),
		.link_done_i(link_done_i), .link_fail_i(link_fail_i), .link_fail_code_i(link_fail_code_i),
		.link_idle_i(link_idle_i), .link_rx_busy_i(link_rx_busy_i));
	msh_link_model lm (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .pl_addr_o(pl_addr_o),
		.pl_wdata_o(pl_wdata_o), .pl_we_o(pl_we_o), .pl_rdata_i(pl_rdata_i),
		.link_start_o(link_start_o), .link_abort_o(link_abort_o), .link_done_i(link_done_i),
		.link_fail_i(link_fail_i), .link_fail_code_i(link_fail_code_i), .link_idle_i(link_idle_i),
		.fail_i(fail_i), .delay_i(delay_i));
	// ----------------------------------------
	// Checking and expectations
	// ----------------------------------------
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic report_and_stop;
		$display("Comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	function automatic logic [15:0] cir_max(logic [15:0] d);
		return (d == DEV_SERIAL) ? CIR_MAX_SERIAL : CIR_MAX_OTHER;
	endfunction
	function automatic logic [15:0] ch_max(logic [15:0] d);
		case (d)
			DEV_MULTIDROP: return CH_MAX_MULTIDROP;
			DEV_SERIAL: return CH_MAX_SERIAL;
			DEV_ETH: return CH_MAX_ETH;
			default: return CH_MAX_SMALL;
		endcase
	endfunction
	function automatic logic [3:0] exp_code(msh_cmd_t c, logic rx);
		if (!(c.dev_type inside {DEV_MULTIDROP, DEV_SERIAL, DEV_ETH, DEV_DNET, DEV_ETH_SMALL}))
			return ERR_DEV;
		if (!(c.proto inside {PROTO_REGACC, PROTO_RAW_WORD, PROTO_RAW_BYTE})) return ERR_PROTO;
		if (c.circuit < NUM_MIN || c.circuit > cir_max(c.dev_type)) return ERR_CIRCUIT;
		if (c.channel < NUM_MIN || c.channel > ch_max(c.dev_type)) return ERR_CHANNEL;
		if (c.dev_type == DEV_SERIAL && rx) return ERR_SHARED;
		return 4'h0;
	endfunction
	// Mode ab: 0 plain, 1 abort during the send, 2 abort raised with execute.
	task automatic run(input msh_cmd_t c, input int ab, input logic rx, input logic fm);
		logic [3:0] e, y;
		logic [15:0] w5, w6, w11;
		logic pb, st, sa;
		int n;
		e = exp_code(c, rx);
		y = (ab != 0) ? 4'h0 : (e != 4'h0) ? e : fm ? 4'h7 : 4'h0;
		w5 = 16'($urandom);
		w6 = 16'($urandom);
		w11 = 16'($urandom);
		lm.mem[base + 5] = w5;
		lm.mem[base + 6] = w6;
		lm.mem[base + 11] = w11;
		@(negedge core_clk_i);
		cmd_i = c;
		link_rx_busy_i = rx;
		fail_i = fm;
		delay_i = (ab == 1) ? 8'h28 : 8'($urandom_range(1, 20));
		exec_i = 1'b1;
		abort_i = (ab == 2);
		pb = 1'b0;
		st = 1'b0;
		sa = 1'b0;
		for (n = 0; n < 300 && done_o !== 1'b1 && err_o !== 1'b1; n++) begin
			if (busy_o === 1'b1) pb = 1'b1;
			if (link_abort_o === 1'b1) sa = 1'b1;
			@(negedge core_clk_i);
			if (link_start_o === 1'b1) begin
				st = 1'b1;
				chk("word_mode", link_req_o.word_mode, c.proto == PROTO_RAW_WORD);
				chk("no_reply", link_req_o.no_reply, c.proto != PROTO_REGACC);
				chk("data_addr", link_req_o.data_addr, w5);
				chk("data_size", link_req_o.data_size, w6);
				chk("reg_offset", link_req_o.reg_offset, w11);
				chk("circuit", link_req_o.cmd.circuit, c.circuit);
				chk("progress", lm.mem[base], {RES_BUSY, c.circuit[7:0]});
				if (ab == 1) abort_i = 1'b1;
			end
		end
		chk("done", done_o, y == 4'h0);
		chk("err", err_o, y != 4'h0);
		chk("start", st, ab != 2 && e == 4'h0);
		chk("abort_req", sa, ab == 1);
		if (ab != 2) chk("busy_run", pb, 1'b1);
		@(negedge core_clk_i);
		chk("pulse", done_o | err_o, 1'b0);
		chk("busy_end", busy_o, 1'b0);
		chk("result", lm.mem[base], {y == 4'h0 ? RES_DONE : {RES_ERR_HI, y}, c.circuit[7:0]});
		repeat (3) begin
			@(negedge core_clk_i);
			chk("no_restart", busy_o | done_o | err_o, 1'b0);
		end
		exec_i = 1'b0;
		abort_i = 1'b0;
		@(negedge core_clk_i);
		$display("Test end dev %0d code %0h abort %0d", c.dev_type, y, ab);
	endtask
	initial begin
		#160000;
		num_errors++;
		report_and_stop();
	end
	initial begin
		msh_cmd_t c;
		int k;
		void'($urandom(6));
		repeat (12) @(negedge core_clk_i);
		rstn_i = 1'b1;
		for (k = 0; k < 48; k++) begin
			c.dev_type = (k % 8 == 4 || k % 16 == 3) ? DEV_SERIAL : devs[$urandom_range(0, 4)];
			c.proto = 16'($urandom_range(1, 3));
			c.circuit = 16'($urandom_range(1, cir_max(c.dev_type)));
			c.channel = 16'($urandom_range(1, ch_max(c.dev_type)));
			case (k % 8)
				0: c.dev_type = 16'($urandom_range(2, 4));
				1: c.proto = k[3] ? 16'h0000 : 16'h0004;
				2: c.circuit = k[3] ? 16'h0000 : cir_max(c.dev_type) + 16'h0001;
				3: c.channel = k[3] ? 16'h0000 : ch_max(c.dev_type) + 16'h0001;
				5: begin
					c.circuit = cir_max(c.dev_type);
					c.channel = ch_max(c.dev_type);
				end
				default: ;
			endcase
			run(c, (k % 8 == 7) ? (k[3] ? 1 : 2) : 0, k % 8 == 4, k % 8 == 6);
		end
		exec_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		rstn_i = 1'b0;
		@(negedge core_clk_i);
		chk("reset", {busy_o, done_o, err_o}, 3'b000);
		exec_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		rstn_i = 1'b1;
		report_and_stop();
	end
endmodule // msh_send_bench
